// *** logic/vcc_top.sv ***
// Comparator control and status: two special registers plus mode register,
// latched and raw outputs, edge flags, interrupt request and reset request.
// Assumes the analog comparator drives cmp_raw; sfr bus is single-cycle.
// Operation
// R01 - Latched and raw outputs for pins
// R02 - Raw output needs no clock
// R03 - Disabled comparator drives routed outputs low
// R04 - Top control bit enables comparator
// R05 - Read-only state bit shows comparison
// R06 - Rising transition sets rising flag
// R07 - Falling transition sets falling flag
// R08 - Flags stay set until software clears
// R09 - Interrupt on both edges
// R10 - Positive hysteresis code select
// R11 - Negative hysteresis code, same coding
// R12 - Negative input select odd pins
// R13 - Positive input select even pins
// R14 - Unused select bits read zero
// R15 - Two-bit response time field
// R16 - Output usable as reset source
// R17 - Mode resets to 10, four modes
// R18 - Edges from latched samples; write 0 clears
`timescale 1ns/1ps
`default_nettype none
module vcc_top
  import vcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Special register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Analog comparator
  input wire logic cmp_raw,
  output logic comparator_enable,
  output logic [1:0] positive_hysteresis_code,
  output logic [1:0] negative_hysteresis_code,
  output logic [1:0] negative_input_select,
  output logic [1:0] positive_input_select,
  output logic [1:0] response_time_mode,
  // Pin and system outputs
  output logic latched_compare_out,
  output logic raw_async_compare_out,
  output logic compare_irq,
  output logic compare_reset_req
);
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] mx;
    logic [1:0] md;
    logic latched;
    logic irq;
    logic rst_req;
    logic [7:0] rdata;
  } vcc_state_t;

  vcc_state_t st_r;
  vcc_state_t st_nxt;
  logic cmp_sync;
  logic rise;
  logic fall;

  // Raw result is asynchronous to clk
  vcc_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_level(cmp_raw),
    .stable_level(cmp_sync)
  );

  vcc_edge u_edge (
    .clk(clk),
    .nrst(nrst),
    .level(st_r.latched),
    .rise(rise),
    .fall(fall)
  );

  function automatic logic hit(input logic [7:0] a);
    hit = (sfr_addr == a);
  endfunction

  always_comb begin
    st_nxt = st_r;
    // Gated by enable so a disabled block reads and routes low
    st_nxt.latched = cmp_sync & st_r.ctl[VCC_CTL_ENABLE]; // R01 R03
    st_nxt.ctl[VCC_CTL_STATE] = st_nxt.latched; // R05
    if (sfr_wr && hit(VCC_ADDR_CONTROL)) begin
      st_nxt.ctl[VCC_CTL_ENABLE] = sfr_wdata[VCC_CTL_ENABLE]; // R04
      st_nxt.ctl[3:0] = sfr_wdata[3:0]; // R10 R11
      // Writing 1 leaves a flag alone; only 0 clears
      if (!sfr_wdata[VCC_CTL_RISE]) begin
        st_nxt.ctl[VCC_CTL_RISE] = 1'b0; // R18
      end
      if (!sfr_wdata[VCC_CTL_FALL]) begin
        st_nxt.ctl[VCC_CTL_FALL] = 1'b0; // R18
      end
    end
    if (sfr_wr && hit(VCC_ADDR_INPUT_SELECT)) begin
      st_nxt.mx = sfr_wdata & VCC_MX_WMASK; // R12 R13 R14
    end
    if (sfr_wr && hit(VCC_ADDR_MODE)) begin
      st_nxt.md = sfr_wdata[1:0]; // R15 R17
    end
    // Set after clear: an edge in the clearing cycle is kept
    if (rise) begin
      st_nxt.ctl[VCC_CTL_RISE] = 1'b1; // R06 R08
    end
    if (fall) begin
      st_nxt.ctl[VCC_CTL_FALL] = 1'b1; // R07 R08
    end
    st_nxt.irq = rise | fall; // R09
    st_nxt.rst_req = st_nxt.latched; // R16
    st_nxt.rdata = 8'h00;
    if (sfr_rd) begin
      if (hit(VCC_ADDR_CONTROL)) begin
        st_nxt.rdata = st_r.ctl;
      end else if (hit(VCC_ADDR_INPUT_SELECT)) begin
        st_nxt.rdata = st_r.mx; // R14
      end else if (hit(VCC_ADDR_MODE)) begin
        st_nxt.rdata = {6'h00, st_r.md};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.ctl <= VCC_RST_CONTROL;
      st_r.mx <= VCC_RST_INPUT_SELECT;
      st_r.md <= VCC_RST_MODE; // R17
    end else begin
      st_r <= st_nxt;
    end
  end

  // Raw output is a deliberate clockless path so it works in stop state
  always_comb begin
    raw_async_compare_out = cmp_raw & st_r.ctl[VCC_CTL_ENABLE]; // R02 R03
  end

  assign sfr_rdata = st_r.rdata;
  assign comparator_enable = st_r.ctl[VCC_CTL_ENABLE];
  assign positive_hysteresis_code = st_r.ctl[VCC_CTL_HYP_LSB +: 2];
  assign negative_hysteresis_code = st_r.ctl[VCC_CTL_HYN_LSB +: 2];
  assign negative_input_select = st_r.mx[VCC_MX_NEG_LSB +: 2];
  assign positive_input_select = st_r.mx[VCC_MX_POS_LSB +: 2];
  assign response_time_mode = st_r.md;
  assign latched_compare_out = st_r.latched;
  assign compare_irq = st_r.irq;
  assign compare_reset_req = st_r.rst_req;

  property p_state_bit;
    @(posedge clk) disable iff (!nrst)
      st_r.ctl[VCC_CTL_STATE] == st_r.latched;
  endproperty
  a_state_bit: assert property (p_state_bit) else $error("state bit differs"); // R05

  property p_disabled_low;
    @(posedge clk) disable iff (!nrst)
      !st_r.ctl[VCC_CTL_ENABLE] |=> !latched_compare_out;
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("output high while off"); // R03

  property p_raw_low;
    @(posedge clk) disable iff (!nrst)
      !comparator_enable |-> !raw_async_compare_out;
  endproperty
  a_raw_low: assert property (p_raw_low) else $error("raw high while off"); // R03

  sequence s_rise_seen;
    !latched_compare_out ##1 latched_compare_out;
  endsequence
  property p_rise_flag;
    @(posedge clk) disable iff (!nrst)
      s_rise_seen |=> st_r.ctl[VCC_CTL_RISE];
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rising flag missed"); // R06

  sequence s_fall_seen;
    latched_compare_out ##1 !latched_compare_out;
  endsequence
  property p_fall_flag;
    @(posedge clk) disable iff (!nrst)
      s_fall_seen |=> st_r.ctl[VCC_CTL_FALL];
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("falling flag missed"); // R07

  property p_flag_sticky;
    @(posedge clk) disable iff (!nrst)
      st_r.ctl[VCC_CTL_RISE] && !(sfr_wr && hit(VCC_ADDR_CONTROL))
      |=> st_r.ctl[VCC_CTL_RISE];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // R08

  property p_irq_edges;
    @(posedge clk) disable iff (!nrst)
      (s_rise_seen or s_fall_seen) |=> compare_irq;
  endproperty
  a_irq_edges: assert property (p_irq_edges) else $error("irq missing"); // R09

  property p_mx_zero;
    @(posedge clk) disable iff (!nrst)
      (st_r.mx & ~VCC_MX_WMASK) == 8'h00;
  endproperty
  a_mx_zero: assert property (p_mx_zero) else $error("unused select bits set"); // R14

  property p_mode_write;
    @(posedge clk) disable iff (!nrst)
      sfr_wr && hit(VCC_ADDR_MODE) |=> response_time_mode == $past(sfr_wdata[1:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode not written"); // R15

  property p_enable_write;
    @(posedge clk) disable iff (!nrst)
      sfr_wr && hit(VCC_ADDR_CONTROL) |=> comparator_enable == $past(sfr_wdata[7]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not written"); // R04

  property p_fall_sticky;
    @(posedge clk) disable iff (!nrst)
      st_r.ctl[VCC_CTL_FALL] && !(sfr_wr && hit(VCC_ADDR_CONTROL))
      |=> st_r.ctl[VCC_CTL_FALL];
  endproperty
  a_fall_sticky: assert property (p_fall_sticky) else $error("fall flag dropped"); // R08

  property p_rise_quiet;
    @(posedge clk) disable iff (!nrst)
      !st_r.ctl[VCC_CTL_RISE] && !rise |=> !st_r.ctl[VCC_CTL_RISE];
  endproperty
  a_rise_quiet: assert property (p_rise_quiet) else $error("rise set alone"); // R06

  property p_fall_quiet;
    @(posedge clk) disable iff (!nrst)
      !st_r.ctl[VCC_CTL_FALL] && !fall |=> !st_r.ctl[VCC_CTL_FALL];
  endproperty
  a_fall_quiet: assert property (p_fall_quiet) else $error("fall set alone"); // R07

  property p_rise_clear;
    @(posedge clk) disable iff (!nrst)
      sfr_wr && hit(VCC_ADDR_CONTROL) && !sfr_wdata[VCC_CTL_RISE] && !rise
      |=> !st_r.ctl[VCC_CTL_RISE];
  endproperty
  a_rise_clear: assert property (p_rise_clear) else $error("rise not cleared"); // R18

  property p_fall_clear;
    @(posedge clk) disable iff (!nrst)
      sfr_wr && hit(VCC_ADDR_CONTROL) && !sfr_wdata[VCC_CTL_FALL] && !fall
      |=> !st_r.ctl[VCC_CTL_FALL];
  endproperty
  a_fall_clear: assert property (p_fall_clear) else $error("fall not cleared"); // R18

  property p_rise_wins;
    @(posedge clk) disable iff (!nrst)
      sfr_wr && hit(VCC_ADDR_CONTROL) && rise |=> st_r.ctl[VCC_CTL_RISE];
  endproperty
  a_rise_wins: assert property (p_rise_wins) else $error("rise lost to clear"); // R06

  property p_fall_wins;
    @(posedge clk) disable iff (!nrst)
      sfr_wr && hit(VCC_ADDR_CONTROL) && fall |=> st_r.ctl[VCC_CTL_FALL];
  endproperty
  a_fall_wins: assert property (p_fall_wins) else $error("fall lost to clear"); // R07

  property p_irq_quiet;
    @(posedge clk) disable iff (!nrst)
      !rise && !fall |=> !compare_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without edge"); // R09

  property p_reset_req;
    @(posedge clk) disable iff (!nrst)
      compare_reset_req == latched_compare_out;
  endproperty
  a_reset_req: assert property (p_reset_req) else $error("reset request differs"); // R16

  property p_latch_follow;
    @(posedge clk) disable iff (!nrst)
      comparator_enable |=> latched_compare_out == $past(cmp_sync);
  endproperty
  a_latch_follow: assert property (p_latch_follow) else $error("latched lags"); // R01

  property p_raw_follow;
    @(posedge clk) disable iff (!nrst)
      comparator_enable |-> raw_async_compare_out == cmp_raw;
  endproperty
  a_raw_follow: assert property (p_raw_follow) else $error("raw differs"); // R02

  property p_ctl_read;
    @(posedge clk) disable iff (!nrst)
      sfr_rd && hit(VCC_ADDR_CONTROL) |=> sfr_rdata == $past(st_r.ctl);
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read wrong"); // R05

  property p_mx_read;
    @(posedge clk) disable iff (!nrst)
      sfr_rd && hit(VCC_ADDR_INPUT_SELECT) |=> sfr_rdata == $past(st_r.mx);
  endproperty
  a_mx_read: assert property (p_mx_read) else $error("select read wrong"); // R14

  property p_mode_read;
    @(posedge clk) disable iff (!nrst)
      sfr_rd && hit(VCC_ADDR_MODE) |=> sfr_rdata == {6'h00, $past(response_time_mode)};
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read wrong"); // R17

  property p_none_read;
    @(posedge clk) disable iff (!nrst)
      sfr_rd && !hit(VCC_ADDR_CONTROL) && !hit(VCC_ADDR_INPUT_SELECT) && !hit(VCC_ADDR_MODE)
      |=> sfr_rdata == 8'h00;
  endproperty
  a_none_read: assert property (p_none_read) else $error("unmapped read nonzero"); // R14

  property p_hyp_write;
    @(posedge clk) disable iff (!nrst)
      sfr_wr && hit(VCC_ADDR_CONTROL)
      |=> positive_hysteresis_code == $past(sfr_wdata[VCC_CTL_HYP_LSB +: 2]);
  endproperty
  a_hyp_write: assert property (p_hyp_write) else $error("positive code wrong"); // R10

  property p_hyn_write;
    @(posedge clk) disable iff (!nrst)
      sfr_wr && hit(VCC_ADDR_CONTROL)
      |=> negative_hysteresis_code == $past(sfr_wdata[VCC_CTL_HYN_LSB +: 2]);
  endproperty
  a_hyn_write: assert property (p_hyn_write) else $error("negative code wrong"); // R11

  property p_neg_write;
    @(posedge clk) disable iff (!nrst)
      sfr_wr && hit(VCC_ADDR_INPUT_SELECT)
      |=> negative_input_select == $past(sfr_wdata[VCC_MX_NEG_LSB +: 2]);
  endproperty
  a_neg_write: assert property (p_neg_write) else $error("negative select wrong"); // R12

  property p_pos_write;
    @(posedge clk) disable iff (!nrst)
      sfr_wr && hit(VCC_ADDR_INPUT_SELECT)
      |=> positive_input_select == $past(sfr_wdata[VCC_MX_POS_LSB +: 2]);
  endproperty
  a_pos_write: assert property (p_pos_write) else $error("positive select wrong"); // R13

  property p_mode_hold;
    @(posedge clk) disable iff (!nrst)
      !(sfr_wr && hit(VCC_ADDR_MODE)) |=> $stable(response_time_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed alone"); // R15

  property p_mx_hold;
    @(posedge clk) disable iff (!nrst)
      !(sfr_wr && hit(VCC_ADDR_INPUT_SELECT)) |=> $stable(st_r.mx);
  endproperty
  a_mx_hold: assert property (p_mx_hold) else $error("select changed alone"); // R12
endmodule
`default_nettype wire

// *** logic/vcc_pkg.sv ***
// Constants for the comparator control and status block.
// Assumes an 8-bit special-register port on the system clock.
package vcc_pkg;
  // Register addresses
  localparam logic [7:0] VCC_ADDR_INPUT_SELECT = 8'h9f;
  localparam logic [7:0] VCC_ADDR_CONTROL = 8'hf8;
  localparam logic [7:0] VCC_ADDR_MODE = 8'h9d;
  // Reset values
  localparam logic [7:0] VCC_RST_INPUT_SELECT = 8'h00;
  localparam logic [7:0] VCC_RST_CONTROL = 8'h00;
  localparam logic [1:0] VCC_RST_MODE = 2'h2;
  // Control register fields
  localparam int VCC_CTL_ENABLE = 7;
  localparam int VCC_CTL_STATE = 6;
  localparam int VCC_CTL_RISE = 5;
  localparam int VCC_CTL_FALL = 4;
  localparam int VCC_CTL_HYP_LSB = 2;
  localparam int VCC_CTL_HYN_LSB = 0;
  // Input select fields
  localparam int VCC_MX_NEG_LSB = 4;
  localparam int VCC_MX_POS_LSB = 0;
  // Write masks of the select and mode registers
  localparam logic [7:0] VCC_MX_WMASK = 8'h33;
  localparam logic [7:0] VCC_MD_WMASK = 8'h03;
  // Bits of a raw input passing the pin synchroniser
  localparam int VCC_SYNC_STAGES = 3;
endpackage

// *** logic/vcc_sync.sv ***
// Three-stage pin synchroniser with agreement filter.
// Assumes one clock; input is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module vcc_sync
  import vcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Signals
  input wire logic pin_level,
  output logic stable_level
);
  typedef struct packed {
    logic [VCC_SYNC_STAGES-1:0] stg;
    logic out;
  } vcc_sync_t;
  vcc_sync_t s_r;
  vcc_sync_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.stg = {s_r.stg[VCC_SYNC_STAGES-2:0], pin_level};
    // First stage is seen only by the second
    if (s_r.stg[1] == s_r.stg[2]) begin
      s_nxt.out = s_r.stg[2];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign stable_level = s_r.out;
endmodule
`default_nettype wire

// *** logic/vcc_edge.sv ***
// Edge detector on the latched comparator output.
// Assumes input already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module vcc_edge
  import vcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Signals
  input wire logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic prev;
  } vcc_edge_t;
  vcc_edge_t e_r;
  vcc_edge_t e_nxt;

  always_comb begin
    e_nxt = e_r;
    e_nxt.prev = level;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      e_r <= '0;
    end else begin
      e_r <= e_nxt;
    end
  end

  // Successive samples compared
  assign rise = level & ~e_r.prev; // R18
  assign fall = ~level & e_r.prev; // R18
endmodule
`default_nettype wire

// *** tb/tb_vcc_top.sv ***
// Self-checking bench for the comparator control block.
// Assumes the register port timing of vcc_top.
`timescale 1ns/1ps
`default_nettype none
module tb_vcc_top import vcc_pkg::*;;
  logic clk, nrst, sfr_wr, sfr_rd, cmp_raw;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic comparator_enable, latched_compare_out, raw_async_compare_out;
  logic compare_irq, compare_reset_req;
  logic [1:0] positive_hysteresis_code, negative_hysteresis_code;
  logic [1:0] negative_input_select, positive_input_select, response_time_mode;
  int mismatches = 0;
  int compares = 0;
  int irq_cnt = 0;

  vcc_top vcc_top_i (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .cmp_raw(cmp_raw),
    .comparator_enable(comparator_enable),
    .positive_hysteresis_code(positive_hysteresis_code),
    .negative_hysteresis_code(negative_hysteresis_code),
    .negative_input_select(negative_input_select),
    .positive_input_select(positive_input_select),
    .response_time_mode(response_time_mode), .latched_compare_out(latched_compare_out),
    .raw_async_compare_out(raw_async_compare_out), .compare_irq(compare_irq),
    .compare_reset_req(compare_reset_req));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Sampled mid-cycle, clear of the edge
  always @(negedge clk) begin
    if (compare_irq === 1'b1) irq_cnt++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    chk(sfr_rdata, e);
    cyc(1);
  endtask

  task automatic give_verdict;
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Tests need under 200 cycles
  initial begin
    #(40 * 1000);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict;
  end

  initial begin
    nrst = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    cmp_raw = 1'b0;
    cyc(10);
    nrst = 1'b1;
    rd(VCC_ADDR_INPUT_SELECT, 8'h00);
    rd(VCC_ADDR_CONTROL, 8'h00);
    rd(VCC_ADDR_MODE, 8'h02);
    chk(8'(response_time_mode), 8'h02);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      wr(VCC_ADDR_INPUT_SELECT, 8'(i * 16 + 3 - i));
      chk(8'(negative_input_select), 8'(i));
      chk(8'(positive_input_select), 8'(3 - i));
      wr(VCC_ADDR_MODE, 8'(i) | 8'hfc);
      chk(8'(response_time_mode), 8'(i));
      rd(VCC_ADDR_MODE, 8'(i));
      wr(VCC_ADDR_CONTROL, 8'(i * 4 + 3 - i));
      chk(8'(positive_hysteresis_code), 8'(i));
      chk(8'(negative_hysteresis_code), 8'(3 - i));
    end
    wr(VCC_ADDR_INPUT_SELECT, 8'hff);
    rd(VCC_ADDR_INPUT_SELECT, 8'h33);
    wr(VCC_ADDR_CONTROL, 8'h40);
    rd(VCC_ADDR_CONTROL, 8'h00);
    $display("test field codes done");
    cmp_raw = 1'b1;
    cyc(8);
    chk(8'(raw_async_compare_out), 8'h00);
    chk(8'(latched_compare_out), 8'h00);
    wr(VCC_ADDR_CONTROL, 8'h80);
    chk(8'(raw_async_compare_out), 8'h01);
    chk(8'(comparator_enable), 8'h01);
    cyc(8);
    chk(8'(latched_compare_out), 8'h01);
    chk(8'(compare_reset_req), 8'h01);
    rd(VCC_ADDR_CONTROL, 8'he0);
    cmp_raw = 1'b0;
    cyc(8);
    chk(8'(raw_async_compare_out), 8'h00);
    rd(VCC_ADDR_CONTROL, 8'hb0);
    cyc(20);
    rd(VCC_ADDR_CONTROL, 8'hb0);
    chk(8'(irq_cnt), 8'h02);
    wr(VCC_ADDR_CONTROL, 8'ha0);
    rd(VCC_ADDR_CONTROL, 8'ha0);
    wr(VCC_ADDR_CONTROL, 8'h80);
    rd(VCC_ADDR_CONTROL, 8'h80);
    $display("test edge flags done");
    // Disabling while high must still leave a falling flag
    cmp_raw = 1'b1;
    cyc(8);
    wr(VCC_ADDR_CONTROL, 8'h30);
    chk(8'(raw_async_compare_out), 8'h00);
    cyc(4);
    chk(8'(latched_compare_out), 8'h00);
    cmp_raw = 1'b0;
    cyc(6);
    rd(VCC_ADDR_CONTROL, 8'h30);
    chk(8'(irq_cnt), 8'h04);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    rd(VCC_ADDR_CONTROL, 8'h30);
    $display("test disable and unmapped done");
    give_verdict;
  end
endmodule
`default_nettype wire
